// File: rtl/qdl_params.svh
`ifndef QDL_PARAMS_SVH
`define QDL_PARAMS_SVH

// Serial frame geometry
`define QDL_FRAME_W      24
`define QDL_PKG_HI       23
`define QDL_PKG_LO       19
`define QDL_CHAN_HI      18
`define QDL_CHAN_LO      17
`define QDL_DATA_HI      13
`define QDL_DATA_LO      0
// Broadcast flag rides above the frame in the FIFO word
`define QDL_BCAST_BIT    24
`define QDL_FIFO_W       25
`define QDL_FIFO_D       8

// Widths of the converter side
`define QDL_CODE_W       14
`define QDL_PKG_W        5
`define QDL_CHANNELS     4

// Reset values
`define QDL_CODE_RST     14'h0000
`define QDL_GND_RST      1'b1

`endif

// File: rtl/qdl_pkg.sv
`include "qdl_params.svh"

package qdl_pkg;

	// Converter code and per-channel arrays
	typedef logic [`QDL_CODE_W-1:0] qdl_code_type;
	typedef logic [`QDL_CHANNELS-1:0][`QDL_CODE_W-1:0] qdl_bank_type;
	typedef logic [`QDL_FIFO_W-1:0] qdl_word_type;

	// Drain machine states
	typedef enum logic [0:0] {
		QDL_IDLE,
		QDL_CHECK
	} qdl_state_type;

	// System-domain state of the top module
	typedef struct packed {
		logic          fs_prev;
		logic          push_v;
		qdl_word_type  push_d;
		qdl_state_type state;
		qdl_word_type  word;
		qdl_bank_type  inreg;
		qdl_bank_type  latch;
		qdl_bank_type  aout;
		logic          rdy;
		logic          dropped;
	} qdl_sys_type;

	// Link-domain state: only the shift register
	typedef struct packed {
		logic [`QDL_FRAME_W-1:0] sreg;
	} qdl_link_type;

endpackage

// File: rtl/qdl_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for pins and foreign-domain levels
module qdl_sync #(
	parameter int W = 1
) (
	// Clock
	input  wire logic         clk_i,
	// Levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// Both stages in one record; first stage feeds only the second
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} qdl_sync_type;

	qdl_sync_type s;       // Registered stages
	qdl_sync_type next_s;  // Next stages

	// Shift one stage per edge
	always_comb begin
		next_s      = s;
		next_s.meta = d_i;
		next_s.sync = s.meta;
	end

	// No reset: a synchroniser settles within two edges anyway
	always_ff @(posedge clk_i) begin
		s <= next_s;
	end

	assign q_o = s.sync;

endmodule // qdl_sync
`default_nettype wire

// File: rtl/qdl_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO with valid/ready on both sides
module qdl_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);

	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} qdl_fifo_type;

	qdl_fifo_type s;       // Registered storage and pointers
	qdl_fifo_type next_s;  // Next storage and pointers
	logic         wr;      // Write accepted
	logic         rd;      // Read accepted

	// Flags straight from the count, so full and empty are exact
	assign in_ready_o  = (s.cnt != (AW+1)'(D));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o  = s.mem[s.rp];
	assign wr          = in_valid_i && in_ready_o;
	assign rd          = out_valid_o && out_ready_i;

	// Pointer and count update
	always_comb begin
		next_s = s;
		if (wr) begin
			next_s.mem[s.wp] = in_data_i;
			next_s.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
		end
		if (rd) begin
			next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
	end

	// Storage keeps contents over reset; pointers clear
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s     <= next_s;
			s.wp  <= '0;
			s.rp  <= '0;
			s.cnt <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // qdl_fifo
`default_nettype wire

// File: rtl/qdl_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

// Summary of operation
// - Sample data on serial clock falling edge
// - Frame sync low gates bit acceptance
// - Frame sync rise moves 24-bit word
// - Own address comes from strap pins
// - Normal mode needs package address match
// - Broadcast skips package check, keeps channel
// - Load high keeps latches and outputs
// - Load low copies all registers together
// - Clear low raises ground flag at once; codes next clock
// - Outputs stay grounded until next load
// - Load low after clear restores codes
// - Load ignored while clear stays low
module qdl_top
	import qdl_pkg::*;
(
	// System clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    nrst_i,
	// Serial link
	input  wire logic                    sclk_i,
	input  wire logic                    din_i,
	input  wire logic                    frame_sync_n_i,
	input  wire logic                    package_addr_enable_i,
	// Straps
	input  wire logic [`QDL_PKG_W-1:0]   package_addr_pins_i,
	// Update control
	input  wire logic                    load_latches_n_i,
	input  wire logic                    clear_outputs_n_i,
	input  wire logic [`QDL_CODE_W-1:0]  sense_ground_level_i,
	// Converter outputs
	output logic      [`QDL_CHANNELS-1:0][`QDL_CODE_W-1:0] analog_outputs_o,
	output logic                         outputs_grounded_o,
	// Status
	output logic                         frame_ready_o,
	output logic                         frame_dropped_o
);

	localparam int SW = 3 + `QDL_PKG_W;

	// Link domain -------------------------------------------------

	qdl_link_type l;       // Registered shift register
	qdl_link_type next_l;  // Next shift register

	// Shift in one bit per falling edge while the frame is open
	always_comb begin
		next_l = l;
		if (!frame_sync_n_i) begin
			next_l.sreg = {l.sreg[`QDL_FRAME_W-2:0], din_i};
		end
	end

	// No reset pin on the link side; only the frame sync frames data
	always_ff @(negedge sclk_i) begin
		l <= next_l;
	end

	// System domain -----------------------------------------------

	logic [SW-1:0]            sync_in;    // Pins into the synchroniser
	logic [SW-1:0]            sync_out;   // Synchronised pins
	logic                     fs_s;       // Frame sync, synchronised
	logic                     ld_n_s;     // Load, synchronised
	logic                     clr_n_s;    // Clear, synchronised
	logic                     package_addr_enable_s;     // Broadcast enable, synchronised
	logic [`QDL_PKG_W-1:0]    pa_s;       // Strap address, synchronised
	logic [`QDL_CODE_W-1:0]   dsg_s;      // Sense ground code, synchronised
	logic                     fifo_in_rdy; // FIFO has room
	logic                     fifo_out_v; // FIFO holds a frame
	qdl_word_type             fifo_out_d; // Oldest frame
	logic                     drain_rdy;  // Drain machine takes a frame
	logic                     grounded;   // Outputs on sense ground
	logic                     accept;     // Frame passes the address check
	logic [1:0]               chan;       // Addressed channel
	qdl_sys_type              s;          // Registered system state
	qdl_sys_type              next_s;     // Next system state

	// Frame sync, load, clear and strap pins cross two flops together; the ground switch also reads clear raw
	assign sync_in = {frame_sync_n_i, load_latches_n_i, clear_outputs_n_i,
		package_addr_pins_i};
	assign fs_s    = sync_out[SW-1];
	assign ld_n_s  = sync_out[SW-2];
	assign clr_n_s = sync_out[SW-3];
	assign pa_s    = sync_out[`QDL_PKG_W-1:0];

	qdl_sync #(
		.W (SW)
	) u_sync (
		.clk_i (sys_clk_i),
		.d_i   (sync_in),
		.q_o   (sync_out)
	);

	// Broadcast enable crosses separately, sampled with the frame
	qdl_sync #(
		.W (1)
	) u_sync_package_addr_enable (
		.clk_i (sys_clk_i),
		.d_i   (package_addr_enable_i),
		.q_o   (package_addr_enable_s)
	);

	// Sense ground code is a pin word too; it is meant to be static,
	// and a change while grounded may show one mixed code for a cycle
	qdl_sync #(
		.W (`QDL_CODE_W)
	) u_sync_dsg (
		.clk_i (sys_clk_i),
		.d_i   (sense_ground_level_i),
		.q_o   (dsg_s)
	);

	// Frames wait here until the drain machine decodes them
	qdl_fifo #(
		.W (`QDL_FIFO_W),
		.D (`QDL_FIFO_D)
	) u_fifo (
		.clk_i       (sys_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (s.push_v),
		.in_ready_o  (fifo_in_rdy),
		.in_data_i   (s.push_d),
		.out_valid_o (fifo_out_v),
		.out_ready_i (drain_rdy),
		.out_data_o  (fifo_out_d)
	);

	// Drain stalls while a frame is being decoded
	assign drain_rdy = (s.state == QDL_IDLE);

	// Address check on the held word
	assign chan   = s.word[`QDL_CHAN_HI:`QDL_CHAN_LO];
	assign accept = s.word[`QDL_BCAST_BIT] ||
		(s.word[`QDL_PKG_HI:`QDL_PKG_LO] == pa_s);

	// Ground switch: set without the clock, released on a load
	always_ff @(posedge sys_clk_i or negedge clear_outputs_n_i) begin
		if (!clear_outputs_n_i) begin
			grounded <= 1'b1;
		end else if (!nrst_i) begin
			grounded <= `QDL_GND_RST;
		end else if (clr_n_s && !ld_n_s) begin
			grounded <= 1'b0;
		end
	end

	// Capture, decode, latch and output staging
	always_comb begin
		next_s         = s;
		next_s.fs_prev = fs_s;
		next_s.dropped = 1'b0;
		next_s.rdy     = fifo_in_rdy;
		// Word is quiet once the frame sync is high, so it is safe to take
		if (!(s.push_v && !fifo_in_rdy)) begin
			next_s.push_v = fs_s && !s.fs_prev;
			next_s.push_d = {package_addr_enable_s, l.sreg};
		end
		case (s.state)
			// Wait for a frame
			QDL_IDLE: begin
				if (fifo_out_v) begin
					next_s.word  = fifo_out_d;
					next_s.state = QDL_CHECK;
				end
			end
			// Route it or drop it
			QDL_CHECK: begin
				if (accept) begin
					next_s.inreg[chan] = s.word[`QDL_DATA_HI:`QDL_DATA_LO];
				end else begin
					next_s.dropped = 1'b1;
				end
				next_s.state = QDL_IDLE;
			end
			default: begin
				next_s.state = QDL_IDLE;
			end
		endcase
		// All latches move together; held while load high or clear low
		if (clr_n_s && !ld_n_s) begin
			next_s.latch = s.inreg;
		end
		// Output stage picks ground level or the latch per channel
		for (int i = 0; i < `QDL_CHANNELS; i++) begin
			next_s.aout[i] = grounded ? dsg_s : s.latch[i];
		end
	end

	// Synchronous reset of all system state
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			s         <= '0;
			s.fs_prev <= 1'b1;
			s.state   <= QDL_IDLE;
			s.inreg   <= {`QDL_CHANNELS{`QDL_CODE_RST}};
			s.latch   <= {`QDL_CHANNELS{`QDL_CODE_RST}};
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from flops
	assign analog_outputs_o   = s.aout;
	assign outputs_grounded_o = grounded;
	assign frame_ready_o      = s.rdy;
	assign frame_dropped_o    = s.dropped;

	// Checks ------------------------------------------------------

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);

	// Bit shifted in on each falling edge inside a frame
	property p_shift;
		@(negedge sclk_i) disable iff (1'b0)
		!frame_sync_n_i |=> l.sreg[0] == $past(din_i);
	endproperty
	a_shift: assert property (p_shift) else $error("bit not shifted");

	// Frame outside the window leaves the register alone
	property p_gate;
		@(negedge sclk_i) disable iff (1'b0)
		frame_sync_n_i |=> $stable(l.sreg);
	endproperty
	a_gate: assert property (p_gate) else $error("shift outside frame");

	// Frame sync rise pushes the captured word
	property p_capture;
		$rose(fs_s) && !(s.push_v && !fifo_in_rdy) |=> s.push_v;
	endproperty
	a_capture: assert property (p_capture) else $error("frame not pushed");

	// Mismatch in normal mode drops the frame
	property p_mismatch;
		s.state == QDL_CHECK && !accept |=> frame_dropped_o && $stable(s.inreg);
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign frame taken");

	// Accepted frame lands in the addressed register
	property p_write;
		s.state == QDL_CHECK && accept |=>
			s.inreg[$past(chan)] == $past(s.word[`QDL_DATA_HI:`QDL_DATA_LO]);
	endproperty
	a_write: assert property (p_write) else $error("register not written");

	// Broadcast frame is never refused and lands in its channel
	property p_bcast;
		s.state == QDL_CHECK && s.word[`QDL_BCAST_BIT] |=>
			!frame_dropped_o &&
			s.inreg[$past(chan)] == $past(s.word[`QDL_DATA_HI:`QDL_DATA_LO]);
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast refused");

	// Load high holds every latch
	property p_hold;
		ld_n_s |=> $stable(s.latch);
	endproperty
	a_hold: assert property (p_hold) else $error("latch moved under hold");

	// Load low copies all registers at once
	property p_load;
		clr_n_s && !ld_n_s |=> s.latch == $past(s.inreg);
	endproperty
	a_load: assert property (p_load) else $error("latches not loaded");

	// Clear pin low means grounded outputs
	property p_clear;
		!clear_outputs_n_i |-> outputs_grounded_o;
	endproperty
	a_clear: assert property (p_clear) else $error("clear not grounding");

	// Grounded outputs stay so while load is high
	property p_stay;
		outputs_grounded_o && ld_n_s |=> outputs_grounded_o;
	endproperty
	a_stay: assert property (p_stay) else $error("ground left early");

	// Load low after release restores latch codes within two edges
	property p_restore;
		clr_n_s && !ld_n_s && clear_outputs_n_i ##1 clear_outputs_n_i |->
			!outputs_grounded_o ##1 analog_outputs_o == $past(s.latch);
	endproperty
	a_restore: assert property (p_restore) else $error("codes not restored");

	// Load ignored while clear is low
	property p_ignore;
		!clr_n_s |-> outputs_grounded_o ##1 $stable(s.latch);
	endproperty
	a_ignore: assert property (p_ignore) else $error("load not ignored");

	// Scenarios worth seeing
	c_accept: cover property (s.state == QDL_CHECK && accept);
	c_drop: cover property (frame_dropped_o);
	c_bcast: cover property (s.state == QDL_CHECK && s.word[`QDL_BCAST_BIT]);
	c_release: cover property ($fell(outputs_grounded_o));

endmodule // qdl_top
`default_nettype wire

// File: sim/qdl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

// Host controller on the far side of the serial write link
module qdl_host_model (
	// Serial link
	output var logic sclk_o,
	output var logic din_o,
	output var logic frame_sync_n_o
);

	// Idle link: clock parked high, no frame open
	initial begin
		sclk_o = 1'b1;
		din_o = 1'b0;
		frame_sync_n_o = 1'b1;
	end

	// One whole frame, MSB first; half is the half period in ns
	task automatic send(input logic [`QDL_FRAME_W-1:0] w, input int half);
		frame_sync_n_o = 1'b0;
		#(half);
		for (int i = `QDL_FRAME_W - 1; i >= 0; i--) begin
			// Data set up while clock high, taken on the fall
			din_o = w[i];
			#(half);
			sclk_o = 1'b0;
			#(half);
			sclk_o = 1'b1;
		end
		#(half);
		frame_sync_n_o = 1'b1;
		// Released line shows the inverse, never a stale bit
		din_o = ~w[0];
		// Clock stands still; gap well above 20 ns between frames
		#(4 * half);
	endtask

	// Free-running clock with no frame open; the device must ignore it
	task automatic idle_clocks(input int n, input int half);
		for (int i = 0; i < n; i++) begin
			din_o = ~din_o;
			#(half);
			sclk_o = 1'b0;
			#(half);
			sclk_o = 1'b1;
		end
	endtask

endmodule // qdl_host_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qdl_params.svh"

// Self-checking bench for the serial load control
module tb;
	import qdl_pkg::*;

	localparam logic [4:0]   OWN_ADDR = 5'h15;    // Strapped package address
	localparam qdl_code_type GND_CODE = 14'h2A5C; // Sense ground code

	logic         sys_clk_i;  // System clock
	logic         nrst_i;     // Sync reset
	logic         sclk;       // Link clock from host
	logic         din;        // Serial data
	logic         frame_sync_n_n;    // Frame window
	logic         package_addr_enable;       // Broadcast enable
	logic         load_n;     // Load control
	logic         clr_n;      // Clear control
	qdl_bank_type aout;       // Output codes
	logic         grounded;   // Outputs on sense ground
	logic         ready;      // FIFO has room
	logic         dropped;    // Frame refused
	int           err_count;  // Mismatches
	int           n_compared; // Comparisons
	int           n_drop = 0; // Refusal pulses seen

	qdl_top i_qdl_top (
		.sys_clk_i             (sys_clk_i),
		.nrst_i                (nrst_i),
		.sclk_i                (sclk),
		.din_i                 (din),
		.frame_sync_n_i        (frame_sync_n_n),
		.package_addr_enable_i (package_addr_enable),
		.package_addr_pins_i   (OWN_ADDR),
		.load_latches_n_i      (load_n),
		.clear_outputs_n_i     (clr_n),
		.sense_ground_level_i  (GND_CODE),
		.analog_outputs_o      (aout),
		.outputs_grounded_o    (grounded),
		.frame_ready_o         (ready),
		.frame_dropped_o       (dropped)
	);

	qdl_host_model i_qdl_host_model (
		.sclk_o         (sclk),
		.din_o          (din),
		.frame_sync_n_o (frame_sync_n_n)
	);

	// 200 MHz system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// Count refusal pulses; one cycle wide so sample every edge
	always @(posedge sys_clk_i) begin
		if (dropped === 1'b1) begin
			n_drop <= n_drop + 1;
		end
	end

	// Ends the run with the verdict
	task automatic give_verdict;
		if (err_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compare a converter code
	task automatic chk_code(input string what, input qdl_code_type exp, input qdl_code_type got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Compare a flag
	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Advance n edges, then land just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// Frame layout: package, channel, spare, data
	function automatic logic [23:0] frame(input logic [4:0] pa, input logic [1:0] ch,
		input qdl_code_type d);
		return {pa, ch, 3'h0, d};
	endfunction

	// Bounded wait for a channel code, then compare
	task automatic wait_code(input int ch, input qdl_code_type exp);
		for (int i = 0; i < 60 && aout[ch] !== exp; i++) begin
			step(1);
		end
		chk_code("output code", exp, aout[ch]);
	endtask

	// Main sequence
	initial begin
		nrst_i = 1'b0;
		load_n = 1'b1;
		clr_n = 1'b1;
		package_addr_enable = 1'b0;
		err_count = 0;
		n_compared = 0;
		step(10);
		nrst_i = 1'b1;
		step(4);
		chk_bit("grounded after reset", 1'b1, grounded);
		chk_code("code after reset", GND_CODE, aout[2]);
		chk_bit("room after reset", 1'b1, ready);
		// Pass-through, two frames with idle link clocks between them
		load_n = 1'b0;
		i_qdl_host_model.send(frame(OWN_ADDR, 2'd0, 14'h1234), 16);
		i_qdl_host_model.idle_clocks(3, 16);
		i_qdl_host_model.send(frame(OWN_ADDR, 2'd3, 14'h0C3A), 16);
		wait_code(0, 14'h1234);
		wait_code(3, 14'h0C3A);
		// Foreign package refused
		i_qdl_host_model.send(frame(OWN_ADDR ^ 5'h01, 2'd1, 14'h3FFF), 16);
		step(30);
		chk_bit("refusal pulse", 1'b1, n_drop == 1);
		chk_code("refused code", 14'h0000, aout[1]);
		// Broadcast: package ignored, channel kept
		package_addr_enable = 1'b1;
		i_qdl_host_model.send(frame(OWN_ADDR ^ 5'h0A, 2'd2, 14'h0ABC), 16);
		wait_code(2, 14'h0ABC);
		chk_code("other channel", 14'h0000, aout[1]);
		chk_bit("broadcast not refused", 1'b1, n_drop == 1);
		step(1);
		package_addr_enable = 1'b0;
		// Load held high: writes stay in the input registers
		load_n = 1'b1;
		i_qdl_host_model.send(frame(OWN_ADDR, 2'd1, 14'h2222), 16);
		i_qdl_host_model.send(frame(OWN_ADDR, 2'd0, 14'h0F0F), 16);
		step(40);
		chk_code("held channel 1", 14'h0000, aout[1]);
		chk_code("held channel 0", 14'h1234, aout[0]);
		load_n = 1'b0;
		wait_code(1, 14'h2222);
		chk_code("same edge channel 0", 14'h0F0F, aout[0]);
		// Clear sets the ground flag at once, without a clock edge
		step(1);
		clr_n = 1'b0;
		#1;
		chk_bit("grounded on clear", 1'b1, grounded);
		step(2);
		chk_code("cleared code", GND_CODE, aout[3]);
		load_n = 1'b1;
		step(2);
		load_n = 1'b0;
		step(10);
		chk_bit("load while cleared", 1'b1, grounded);
		chk_code("code while cleared", GND_CODE, aout[0]);
		// Clear released with load high: still grounded
		load_n = 1'b1;
		clr_n = 1'b1;
		step(20);
		chk_bit("grounded after clear", 1'b1, grounded);
		chk_code("code after clear", GND_CODE, aout[1]);
		load_n = 1'b0;
		wait_code(0, 14'h0F0F);
		chk_code("restored channel 3", 14'h0C3A, aout[3]);
		chk_bit("released ground", 1'b0, grounded);
		give_verdict();
	end

	// Watchdog, far beyond the expected run of a few microseconds
	initial begin
		#100000;
		err_count++;
		give_verdict();
	end

endmodule // tb
`default_nettype wire
